// File: plc_regs.svh
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH
// Register indices (printed offsets are not all multiples of four)
`define PLC_IDX_CP        4'h9
`define PLC_IDX_CAL       4'hA
`define PLC_IDX_PD        4'hB
`define PLC_IDX_EXACT     4'hC
// Reset values
`define PLC_RST_CP        24'h547264
`define PLC_RST_CAL       24'h002046
`define PLC_RST_PD        24'h07C021
`define PLC_RST_EXACT     24'h000000
// Charge pump register fields
`define PLC_CP_DN_LSB     0
`define PLC_CP_DN_MSB     6
`define PLC_CP_UP_LSB     7
`define PLC_CP_UP_MSB     13
`define PLC_CP_OFS_LSB    14
`define PLC_CP_OFS_MSB    20
`define PLC_CP_OFS_UP     21
`define PLC_CP_OFS_DN     22
`define PLC_CP_HIK        23
// Calibration register fields
`define PLC_CAL_LEN_LSB   0
`define PLC_CAL_LEN_MSB   2
`define PLC_CAL_DIS       11
`define PLC_CAL_CLK_LSB   13
`define PLC_CAL_CLK_MSB   14
// Phase detector register fields
`define PLC_PD_INV        4
`define PLC_PD_UP_EN      5
`define PLC_PD_DN_EN      6
`define PLC_PD_F_UP       9
`define PLC_PD_F_DN       10
`define PLC_PD_F_MID      11
// Divider ratios for the calibration clock select
`define PLC_DIV_0         6'h01
`define PLC_DIV_1         6'h04
`define PLC_DIV_2         6'h10
`define PLC_DIV_3         6'h20
// Measurement lengths in reference-divider cycles
`define PLC_MEAS_0        9'h001
`define PLC_MEAS_1        9'h002
`define PLC_MEAS_2        9'h004
`define PLC_MEAS_3        9'h008
`define PLC_MEAS_4        9'h020
`define PLC_MEAS_5        9'h040
`define PLC_MEAS_6        9'h080
`define PLC_MEAS_7        9'h100
`define PLC_EXACT_INVALID 24'h000001
`define PLC_PSLVERR_OK    1'b0
`endif

// File: plc_pkg.sv
package plc_pkg;
    typedef logic [23:0] plc_word_t;
    typedef logic [6:0]  plc_code_t;
    typedef enum logic [3:0] {
        PLC_PUMP_NORMAL = 4'b0001,
        PLC_PUMP_UP     = 4'b0010,
        PLC_PUMP_DN     = 4'b0100,
        PLC_PUMP_MID    = 4'b1000
    } plc_pump_e;
endpackage

// File: plc_loop_cfg.sv
`include "plc_regs.svh"
// Summary of operation
// - Down gain code, 7 bits at [6:0], 20 uA steps, resets to 100.
// - Up gain code, 7 bits at [13:7], 20 uA steps, resets to 100.
// - Offset magnitude code at [20:14], 5 uA steps, resets to 81.
// - Bit 21 applies offset upward when set; resets to zero.
// - Bit 22 applies offset downward when set; resets to one.
// - Bit 23 selects high-current pump mode adding 3 mA.
// - Three-bit code picks 1,2,4,8,32,64,128,256 measurement cycles; reset 6.
// - Bit 11 set disables automatic calibration; resets to zero.
// - Two-bit select divides reference by 1,4,16,32; reset 1; at most 50 MHz.
// - Phase-select bit inverts detector polarity; resets to zero.
// - Up pulses reach the pump only while up enable is set.
// - Down pulses reach the pump only while down enable is set.
// - Force-up holds up on unless forced down; force-down likewise.
// - Mid-rail forcing applies only when neither force-up nor force-down.
// - Channel count zero disables exact mode; one is invalid; two up valid.
// - Exact mode gives zero error at multiples of the correction rate.
module plc_loop_cfg (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Charge pump settings
    output plc_pkg::plc_code_t      charge_pump_dn_gain,
    output plc_pkg::plc_code_t      charge_pump_up_gain,
    output plc_pkg::plc_code_t      charge_pump_offset,
    output logic                    charge_pump_offset_up,
    output logic                    charge_pump_offset_dn,
    output logic                    high_current_pump_mode,
    // Calibration machine settings
    output logic      [8:0]         cal_meas_cycles,
    output logic                    cal_enable,
    output logic      [5:0]         internal_serial_clock_div,
    // Phase detector pulses and pump drive
    input  wire logic               phase_detector_up,
    input  wire logic               phase_detector_dn,
    output logic                    charge_pump_up,
    output logic                    charge_pump_dn,
    output logic                    charge_pump_mid_rail,
    // Exact frequency modulator settings
    output plc_pkg::plc_word_t      exact_channels,
    output logic                    exact_mode_active,
    output logic                    exact_value_invalid
);
    import plc_pkg::*;

    plc_word_t cp_r;
    plc_word_t cal_r;
    plc_word_t pd_r;
    plc_word_t exact_r;
    logic [31:0] prdata_nxt;
    logic        up_s1_r;
    logic        up_s2_r;
    logic        dn_s1_r;
    logic        dn_s2_r;
    plc_pump_e   pump_state;
    localparam plc_word_t CP_RST = `PLC_RST_CP;

    function automatic plc_word_t merge_bytes(input plc_word_t old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0] strb);
        plc_word_t res;
        res = old_v;
        for (int i = 0; i < 3; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Decode: byte address is four times the printed index
    wire logic        addr_aligned = (paddr[1:0] == 2'h0);
    wire logic [5:0]  word_idx     = paddr[7:2];
    wire logic        hit_cp    = addr_aligned && (word_idx == {2'h0, `PLC_IDX_CP});
    wire logic        hit_cal   = addr_aligned && (word_idx == {2'h0, `PLC_IDX_CAL});
    wire logic        hit_pd    = addr_aligned && (word_idx == {2'h0, `PLC_IDX_PD});
    wire logic        hit_exact = addr_aligned && (word_idx == {2'h0, `PLC_IDX_EXACT});
    wire logic        hit_any   = hit_cp | hit_cal | hit_pd | hit_exact;
    // Access phase completes two cycles after penable rises (one wait state); pready is registered
    wire logic        access    = psel && penable && !pready;
    wire logic        wr_go     = access && pwrite;

    wire plc_word_t   rd_word = hit_cp    ? cp_r :
                                hit_cal   ? cal_r :
                                hit_pd    ? pd_r :
                                hit_exact ? exact_r : 24'h000000;

    // Whole register stored at once, so outputs never see half a write
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cp_r    <= `PLC_RST_CP;
            cal_r   <= `PLC_RST_CAL;
            pd_r    <= `PLC_RST_PD;
            exact_r <= `PLC_RST_EXACT;
        end else if (wr_go) begin
            // Reserved bits are stored as written and read back unchanged
            if (hit_cp)    cp_r    <= merge_bytes(cp_r, pwdata, pstrb);
            if (hit_cal)   cal_r   <= merge_bytes(cal_r, pwdata, pstrb);
            if (hit_pd)    pd_r    <= merge_bytes(pd_r, pwdata, pstrb);
            if (hit_exact) exact_r <= merge_bytes(exact_r, pwdata, pstrb);
        end
    end

    assign prdata_nxt = (access && !pwrite) ? {8'h00, rd_word} : 32'h00000000;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= access;
            // Unmapped address answers with an error and zero data
            pslverr <= access && !hit_any;
            prdata  <= prdata_nxt;
        end
    end

    // Field decode
    wire logic [2:0] meas_code = cal_r[`PLC_CAL_LEN_MSB:`PLC_CAL_LEN_LSB];
    wire logic [1:0] clk_code  = cal_r[`PLC_CAL_CLK_MSB:`PLC_CAL_CLK_LSB];
    wire logic [8:0] meas_nxt  = (meas_code == 3'h0) ? `PLC_MEAS_0 :
                                 (meas_code == 3'h1) ? `PLC_MEAS_1 :
                                 (meas_code == 3'h2) ? `PLC_MEAS_2 :
                                 (meas_code == 3'h3) ? `PLC_MEAS_3 :
                                 (meas_code == 3'h4) ? `PLC_MEAS_4 :
                                 (meas_code == 3'h5) ? `PLC_MEAS_5 :
                                 (meas_code == 3'h6) ? `PLC_MEAS_6 :
                                                       `PLC_MEAS_7;
    wire logic [5:0] div_nxt   = (clk_code == 2'h0) ? `PLC_DIV_0 :
                                 (clk_code == 2'h1) ? `PLC_DIV_1 :
                                 (clk_code == 2'h2) ? `PLC_DIV_2 :
                                                      `PLC_DIV_3;

    // Pump forcing priority: up/down force over mid rail over normal
    wire logic f_up  = pd_r[`PLC_PD_F_UP];
    wire logic f_dn  = pd_r[`PLC_PD_F_DN];
    wire logic f_mid = pd_r[`PLC_PD_F_MID];
    wire plc_pump_e pump_nxt = (f_up && !f_dn) ? PLC_PUMP_UP :
                               (f_dn && !f_up) ? PLC_PUMP_DN :
                               (f_mid && !f_up && !f_dn) ? PLC_PUMP_MID :
                               PLC_PUMP_NORMAL;
    // Both forces set cancel each other; pump then follows the detector

    // Detector polarity swap before gating
    wire logic inv    = pd_r[`PLC_PD_INV];
    wire logic pd_up  = inv ? dn_s2_r : up_s2_r;
    wire logic pd_dn  = inv ? up_s2_r : dn_s2_r;
    wire logic norm_up = pd_up && pd_r[`PLC_PD_UP_EN];
    wire logic norm_dn = pd_dn && pd_r[`PLC_PD_DN_EN];

    logic up_nxt;
    logic dn_nxt;
    logic mid_nxt;
    always_comb begin
        up_nxt  = 1'b0;
        dn_nxt  = 1'b0;
        mid_nxt = 1'b0;
        case (pump_state)
            PLC_PUMP_UP: begin
                up_nxt = 1'b1;
            end
            PLC_PUMP_DN: begin
                dn_nxt = 1'b1;
            end
            PLC_PUMP_MID: begin
                mid_nxt = 1'b1;
            end
            PLC_PUMP_NORMAL: begin
                up_nxt = norm_up;
                dn_nxt = norm_dn;
            end
            default: begin
                up_nxt = 1'b0;
            end
        endcase
    end

    // Detector pulses come from the analog side, so they are synchronised
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            up_s1_r <= 1'b0;
            up_s2_r <= 1'b0;
            dn_s1_r <= 1'b0;
            dn_s2_r <= 1'b0;
        end else begin
            up_s1_r <= phase_detector_up;
            up_s2_r <= up_s1_r;
            dn_s1_r <= phase_detector_dn;
            dn_s2_r <= dn_s1_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pump_state <= PLC_PUMP_NORMAL;
        end else begin
            pump_state <= pump_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            charge_pump_up       <= 1'b0;
            charge_pump_dn       <= 1'b0;
            charge_pump_mid_rail <= 1'b0;
        end else begin
            charge_pump_up       <= up_nxt;
            charge_pump_dn       <= dn_nxt;
            charge_pump_mid_rail <= mid_nxt;
        end
    end

    // Field outputs registered from the stored words
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            charge_pump_dn_gain <= CP_RST[`PLC_CP_DN_MSB:`PLC_CP_DN_LSB];
            charge_pump_up_gain <= CP_RST[`PLC_CP_UP_MSB:`PLC_CP_UP_LSB];
            charge_pump_offset  <= CP_RST[`PLC_CP_OFS_MSB:`PLC_CP_OFS_LSB];
            charge_pump_offset_up     <= CP_RST[`PLC_CP_OFS_UP];
            charge_pump_offset_dn     <= CP_RST[`PLC_CP_OFS_DN];
            high_current_pump_mode    <= CP_RST[`PLC_CP_HIK];
            cal_meas_cycles           <= `PLC_MEAS_6;
            cal_enable                <= 1'b1;
            internal_serial_clock_div <= `PLC_DIV_1;
            exact_channels            <= `PLC_RST_EXACT;
            exact_mode_active         <= 1'b0;
            exact_value_invalid       <= 1'b0;
        end else begin
            charge_pump_dn_gain    <= cp_r[`PLC_CP_DN_MSB:`PLC_CP_DN_LSB];
            charge_pump_up_gain    <= cp_r[`PLC_CP_UP_MSB:`PLC_CP_UP_LSB];
            charge_pump_offset     <= cp_r[`PLC_CP_OFS_MSB:`PLC_CP_OFS_LSB];
            charge_pump_offset_up  <= cp_r[`PLC_CP_OFS_UP];
            charge_pump_offset_dn  <= cp_r[`PLC_CP_OFS_DN];
            high_current_pump_mode <= cp_r[`PLC_CP_HIK];
            cal_meas_cycles        <= meas_nxt;
            cal_enable             <= !cal_r[`PLC_CAL_DIS];
            internal_serial_clock_div <= div_nxt;
            exact_channels         <= exact_r;
            // Value one is not a usable count; exact mode stays off for it
            exact_mode_active      <= (exact_r != `PLC_RST_EXACT) &&
                                      (exact_r != `PLC_EXACT_INVALID);
            exact_value_invalid    <= (exact_r == `PLC_EXACT_INVALID);
        end
    end
endmodule

// File: plc_loop_cfg_props.sv
module plc_loop_cfg_props
    import plc_pkg::*;
(
    // Clock and reset
    input wire logic               mclk,
    input wire logic               rst_n,
    // APB slave
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [3:0]         pstrb,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // Decoded settings
    input wire plc_code_t          charge_pump_dn_gain,
    input wire logic               charge_pump_offset_dn,
    input wire logic [8:0]         cal_meas_cycles,
    input wire logic [5:0]         internal_serial_clock_div,
    input wire plc_word_t          exact_channels,
    input wire logic               exact_mode_active,
    input wire logic               exact_value_invalid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire logic take_w = psel && penable && !pready;
    wire logic hit_w  = paddr inside {8'h24, 8'h28, 8'h2C, 8'h30};
    wire logic cpw_w  = take_w && pwrite && paddr == 8'h24 && pstrb == 4'hF;

    a_ready_wait: assert property (take_w |=> pready)
        else $error("no ready after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_cause: assert property (pready |-> $past(take_w))
        else $error("ready without access");
    a_err_unmapped: assert property (pready |-> pslverr == !$past(hit_w))
        else $error("error response wrong");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    // Own clock and no disable: the reset cycle itself is the cause
    a_reset_fields: assert property (@(posedge mclk) disable iff (1'b0)
        !rst_n |=> charge_pump_dn_gain == 7'h64 && charge_pump_offset_dn
            && cal_meas_cycles == 9'h080) else $error("reset fields wrong");
    a_cp_write: assert property (cpw_w |->
        ##2 charge_pump_dn_gain == $past(pwdata[6:0], 2))
        else $error("gain field not updated");
    a_meas_code: assert property (cal_meas_cycles inside
        {9'h001, 9'h002, 9'h004, 9'h008, 9'h020, 9'h040, 9'h080, 9'h100})
        else $error("bad measurement length");
    a_div_code: assert property (internal_serial_clock_div inside
        {6'h01, 6'h04, 6'h10, 6'h20}) else $error("bad clock divider");
    a_exact_flags: assert property (
        exact_mode_active == (exact_channels >= 24'h2)
        && exact_value_invalid == (exact_channels == 24'h1))
        else $error("exact flags wrong");

    c_write: cover property (cpw_w);
    c_error: cover property (pready && pslverr);
    c_invalid: cover property (exact_value_invalid);
endmodule

bind plc_loop_cfg plc_loop_cfg_props plc_loop_cfg_props_i (
    .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .charge_pump_dn_gain, .charge_pump_offset_dn,
    .cal_meas_cycles, .internal_serial_clock_div, .exact_channels,
    .exact_mode_active, .exact_value_invalid
);

// File: tb_top.sv
`include "plc_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import plc_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d, r; logic [3:0] s;
                    logic e;} plc_row_s;
    typedef struct {logic [31:0] w; logic [1:0] pd; logic [2:0] x;} plc_pd_s;
    localparam logic [7:0] A_CP  = {2'h0, `PLC_IDX_CP, 2'h0};
    localparam logic [7:0] A_CAL = {2'h0, `PLC_IDX_CAL, 2'h0};
    localparam logic [7:0] A_PD  = {2'h0, `PLC_IDX_PD, 2'h0};
    localparam logic [7:0] A_EX  = {2'h0, `PLC_IDX_EXACT, 2'h0};
    logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, phase_detector_up = 1'b0;
    logic        phase_detector_dn = 1'b0, pready, pslverr, erv;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic [3:0]  pstrb = 4'h0;
    plc_code_t   charge_pump_dn_gain, charge_pump_up_gain, charge_pump_offset;
    logic        charge_pump_offset_up, charge_pump_offset_dn, cal_enable;
    logic        high_current_pump_mode, charge_pump_up, charge_pump_dn;
    logic        charge_pump_mid_rail, exact_mode_active, exact_value_invalid;
    logic [8:0]  cal_meas_cycles;
    logic [5:0]  internal_serial_clock_div;
    plc_word_t   exact_channels;
    int          err_total = 0, n_checks = 0;
    logic [7:0]  ra [4] = '{A_CP, A_CAL, A_PD, A_EX};
    logic [23:0] rv [4] = '{24'h547264, 24'h2046, 24'h7C021, 24'h0};
    logic [8:0]  meas [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h020,
                              9'h040, 9'h080, 9'h100};
    logic [5:0]  divs [4] = '{6'h01, 6'h04, 6'h10, 6'h20};
    logic [23:0] exv [4] = '{24'h0, 24'h1, 24'h2, 24'hFFFFFF};
    plc_row_s rows [7] = '{
        '{A_CP, 32'hFFFFFFFF, 32'h00FFFFFF, 4'hF, 1'b0},
        '{A_CP, 32'h11223344, 32'h00FFFF44, 4'h1, 1'b0},
        '{A_CAL, 32'h12345678, 32'h00345678, 4'hF, 1'b0},
        '{A_PD, 32'h000FF071, 32'h000FF071, 4'hF, 1'b0},
        '{A_EX, 32'h00000001, 32'h00000001, 4'hF, 1'b0},
        '{8'h20, 32'h00001234, 32'h0, 4'hF, 1'b1},
        '{8'h25, 32'h00005678, 32'h0, 4'hF, 1'b1}};
    plc_pd_s pds [10] = '{
        '{32'h07C061, 2'h2, 3'h4}, '{32'h07C061, 2'h1, 3'h2},
        '{32'h07C041, 2'h3, 3'h2}, '{32'h07C021, 2'h3, 3'h4},
        '{32'h07C071, 2'h2, 3'h2}, '{32'h07C261, 2'h0, 3'h4},
        '{32'h07C461, 2'h0, 3'h2}, '{32'h07C661, 2'h2, 3'h4},
        '{32'h07C861, 2'h0, 3'h1}, '{32'h07CA61, 2'h0, 3'h4}};

    plc_loop_cfg plc_loop_cfg_i (
        .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .charge_pump_dn_gain, .charge_pump_up_gain,
        .charge_pump_offset, .charge_pump_offset_up, .charge_pump_offset_dn,
        .high_current_pump_mode, .cal_meas_cycles, .cal_enable,
        .internal_serial_clock_div, .phase_detector_up, .phase_detector_dn,
        .charge_pump_up, .charge_pump_dn, .charge_pump_mid_rail,
        .exact_channels, .exact_mode_active, .exact_value_invalid);

    always #5 mclk = ~mclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Values read at the edge are those before it, so no race with the slave
    task automatic apb(input logic [7:0] a, input logic wr,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 4'hF, rdv, erv);
        repeat (4) @(posedge mclk);
    endtask

    task automatic reset_check();
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        foreach (ra[k]) begin
            apb(ra[k], 1'b0, 32'h0, 4'h0, rdv, erv);
            check(rdv, {8'h0, rv[k]});
        end
        check(charge_pump_dn_gain, 7'h64);
        check(charge_pump_up_gain, 7'h64);
        check(charge_pump_offset, 7'h51);
        check({charge_pump_offset_up, charge_pump_offset_dn,
               high_current_pump_mode}, 3'h2);
        check(cal_meas_cycles, 9'h080);
        check({cal_enable, internal_serial_clock_div}, 7'h44);
        check({exact_mode_active, exact_value_invalid}, 2'h0);
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        conclude();
    end

    initial begin
        reset_check();
        foreach (rows[i]) begin
            apb(rows[i].a, 1'b1, rows[i].d, rows[i].s, rdv, erv);
            check(erv, rows[i].e);
            apb(rows[i].a, 1'b0, 32'h0, 4'h0, rdv, erv);
            check(rdv, rows[i].r);
            check(erv, rows[i].e);
        end
        wr(A_CP, 32'h00A5A5A5);
        check(charge_pump_dn_gain, 7'h25);
        check(charge_pump_up_gain, 7'h4B);
        check(charge_pump_offset, 7'h16);
        check({charge_pump_offset_up, charge_pump_offset_dn,
               high_current_pump_mode}, 3'h5);
        for (int i = 0; i < 8; i++) begin
            // Divider code cycles 0 to 3, so divide by one is used too; every length code is checked
            wr(A_CAL, (32'(i % 4) << 13) | 32'(i) | (i[0] ? 32'h800 : 32'h0));
            check(cal_meas_cycles, meas[i]);
            check(internal_serial_clock_div, divs[i % 4]);
            check(cal_enable, {31'h0, ~i[0]});
        end
        foreach (exv[k]) begin
            wr(A_EX, {8'h0, exv[k]});
            check(exact_channels, exv[k]);
            check(exact_mode_active, exv[k] > 24'h1);
            check(exact_value_invalid, exv[k] == 24'h1);
        end
        foreach (pds[k]) begin
            phase_detector_up <= pds[k].pd[1];
            phase_detector_dn <= pds[k].pd[0];
            wr(A_PD, pds[k].w);
            check({charge_pump_up, charge_pump_dn, charge_pump_mid_rail},
                  pds[k].x);
        end
        reset_check();
        conclude();
    end
endmodule
